// ---- rtl/sleep_clock_gating.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "sleep_gate_map.svh"
module sleep_clock_gating
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        unit_access,
  input  wire logic [1:0]  unit_sel,
  output logic             unit_fault,
  output logic             pwm_clk_en,
  output logic             adc_clk_en,
  output logic             wdt_clk_en,
  output logic             hib_clk_en,
  output logic [1:0]       converter_sample_rate,
  output logic             irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0]                run_clock_gate_reg_ff;
  logic [31:0]                sleep_clock_gate_reg_ff;
  logic [31:0]                deep_sleep_clock_gate_reg_ff;
  logic [31:0]                run_clock_config_reg_ff;
  sleep_gate_pkg::power_mode_t mode_ff;
  logic [1:0]                 status_ff;
  logic [1:0]                 mask_ff;
  logic [31:0]                act_gate;
  logic [31:0]                nxt_rdata;
  logic                       nxt_err;
  logic                       wr_hit;
  logic                       rd_hit;
  logic                       mode_wr;
  logic                       fault_evt;
  logic                       gate_on;

  // read data launched in first access cycle; writes commit when pready is sampled
  assign wr_hit = psel && penable && pready && pwrite;
  assign rd_hit = psel && penable && !pready && !pwrite;
  assign mode_wr = wr_hit && (paddr == `MODE_CTRL_OFS);

  // ----------------------------------------
  // gating selection
  // ----------------------------------------
  always_comb
  begin
    act_gate = run_clock_gate_reg_ff;
    if (run_clock_config_reg_ff[`ACG_BIT])
    begin
      case (mode_ff)
        sleep_gate_pkg::MODE_SLEEP: act_gate = sleep_clock_gate_reg_ff;
        sleep_gate_pkg::MODE_DEEP:  act_gate = deep_sleep_clock_gate_reg_ff;
        default:                    act_gate = run_clock_gate_reg_ff;
      endcase
    end
  end

  function automatic logic unit_on(input logic [31:0] g, input logic [1:0] u);
    case (u)
      `UNIT_PWM: unit_on = g[`PWM_BIT];
      `UNIT_ADC: unit_on = g[`ADC_BIT];
      `UNIT_WDT: unit_on = g[`WDT_BIT];
      default:   unit_on = g[`HIB_BIT];
    endcase
  endfunction : unit_on

  assign gate_on = unit_on(act_gate, unit_sel);
  assign fault_evt = unit_access && !gate_on;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwm_clk_en            <= 1'b0;
      adc_clk_en            <= 1'b0;
      wdt_clk_en            <= 1'b0;
      hib_clk_en            <= 1'b1;
      converter_sample_rate <= `RATE_125K;
      unit_fault            <= 1'b0;
    end
    else
    begin
      pwm_clk_en            <= act_gate[`PWM_BIT];
      adc_clk_en            <= act_gate[`ADC_BIT];
      wdt_clk_en            <= act_gate[`WDT_BIT];
      hib_clk_en            <= act_gate[`HIB_BIT];
      converter_sample_rate <= act_gate[`RATE_MSB:`RATE_LSB];
      unit_fault            <= fault_evt;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_clock_gate_reg_ff        <= `GATE_RESET;
      sleep_clock_gate_reg_ff      <= `GATE_RESET;
      deep_sleep_clock_gate_reg_ff <= `GATE_RESET;
      run_clock_config_reg_ff      <= `CFG_RESET;
      mask_ff                      <= 2'h0;
    end
    else if (wr_hit)
    begin
      // only writable bits stored, reserved stay zero
      case (paddr)
        `RUN_GATE_OFS:   run_clock_gate_reg_ff <= pwdata & `GATE_WR_MASK;
        `SLEEP_GATE_OFS: sleep_clock_gate_reg_ff <= pwdata & `GATE_WR_MASK;
        `DEEP_GATE_OFS:  deep_sleep_clock_gate_reg_ff <= pwdata & `GATE_WR_MASK;
        `RUN_CFG_OFS:    run_clock_config_reg_ff <= pwdata & `CFG_WR_MASK;
        `INT_MASK_OFS:   mask_ff <= pwdata[1:0];
        default:         mask_ff <= mask_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mode_ff <= sleep_gate_pkg::MODE_RUN;
    else if (mode_wr)
    begin
      case (pwdata[1:0])
        2'h1:    mode_ff <= sleep_gate_pkg::MODE_SLEEP;
        2'h2:    mode_ff <= sleep_gate_pkg::MODE_DEEP;
        default: mode_ff <= sleep_gate_pkg::MODE_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // interrupt status: set wins over read-clear
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      status_ff <= 2'h0;
    else
    begin
      status_ff[`EVT_FAULT_BIT] <= fault_evt
        || (status_ff[`EVT_FAULT_BIT] && !(rd_hit && paddr == `INT_STATUS_OFS));
      status_ff[`EVT_MODE_BIT] <= mode_wr
        || (status_ff[`EVT_MODE_BIT] && !(rd_hit && paddr == `INT_STATUS_OFS));
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(status_ff & mask_ff);
  end

  // ----------------------------------------
  // apb read and answer
  // ----------------------------------------
  always_comb
  begin
    nxt_err = 1'b0;
    case (paddr)
      `RUN_GATE_OFS:   nxt_rdata = run_clock_gate_reg_ff;
      `SLEEP_GATE_OFS: nxt_rdata = sleep_clock_gate_reg_ff;
      `DEEP_GATE_OFS:  nxt_rdata = deep_sleep_clock_gate_reg_ff;
      `RUN_CFG_OFS:    nxt_rdata = run_clock_config_reg_ff;
      `MODE_CTRL_OFS:  nxt_rdata = {30'h0, mode_ff};
      `INT_STATUS_OFS: nxt_rdata = {30'h0, status_ff};
      `INT_MASK_OFS:   nxt_rdata = {30'h0, mask_ff};
      default:
      begin
        nxt_rdata = 32'h0;
        nxt_err   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && nxt_err;
      prdata  <= rd_hit ? nxt_rdata : 32'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pwm_gate_sleep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_SLEEP)
    |=> pwm_clk_en == $past(sleep_clock_gate_reg_ff[`PWM_BIT]))
    else $error("pwm clock enable does not follow sleep bit");
  a_adc_gate_sleep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_SLEEP)
    |=> adc_clk_en == $past(sleep_clock_gate_reg_ff[`ADC_BIT]))
    else $error("converter clock enable does not follow sleep bit");
  a_wdt_gate_sleep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_SLEEP)
    |=> wdt_clk_en == $past(sleep_clock_gate_reg_ff[`WDT_BIT]))
    else $error("watchdog clock enable does not follow sleep bit");
  a_hib_gate_sleep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_SLEEP)
    |=> hib_clk_en == $past(sleep_clock_gate_reg_ff[`HIB_BIT]))
    else $error("hibernation clock enable does not follow sleep bit");
  a_fault_on_gated: assert property (@(posedge mclk) disable iff (!resetn)
    (unit_access && !unit_on(act_gate, unit_sel)) |=> unit_fault ##1 status_ff[0])
    else $error("gated unit access did not fault");
  a_rate_follows: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 converter_sample_rate == $past(act_gate[`RATE_MSB:`RATE_LSB]))
    else $error("sample rate does not follow active register");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (sleep_clock_gate_reg_ff & ~`GATE_WR_MASK) == 32'h0)
    else $error("reserved sleep bits not zero");
  a_run_when_noacg: assert property (@(posedge mclk) disable iff (!resetn)
    !run_clock_config_reg_ff[`ACG_BIT] |=> wdt_clk_en == $past(run_clock_gate_reg_ff[`WDT_BIT]))
    else $error("run register not applied with auto gating off");
  a_deep_select: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_DEEP)
    |=> pwm_clk_en == $past(deep_sleep_clock_gate_reg_ff[`PWM_BIT]))
    else $error("deep register not applied in deep sleep");

  // ----------------------------------------
  // further checks
  // ----------------------------------------
  a_wdt_gate_deep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_DEEP)
    |=> wdt_clk_en == $past(deep_sleep_clock_gate_reg_ff[`WDT_BIT]))
    else $error("watchdog enable does not follow deep register");
  a_hib_gate_deep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_DEEP)
    |=> hib_clk_en == $past(deep_sleep_clock_gate_reg_ff[`HIB_BIT]))
    else $error("hibernation enable does not follow deep register");
  a_adc_gate_noacg: assert property (@(posedge mclk) disable iff (!resetn)
    !run_clock_config_reg_ff[`ACG_BIT]
    |=> adc_clk_en == $past(run_clock_gate_reg_ff[`ADC_BIT]))
    else $error("converter enable not from run register");
  a_pwm_gate_noacg: assert property (@(posedge mclk) disable iff (!resetn)
    !run_clock_config_reg_ff[`ACG_BIT]
    |=> pwm_clk_en == $past(run_clock_gate_reg_ff[`PWM_BIT]))
    else $error("pwm enable not from run register");
  a_rate_in_sleep: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_config_reg_ff[`ACG_BIT] && mode_ff == sleep_gate_pkg::MODE_SLEEP)
    |=> converter_sample_rate == $past(sleep_clock_gate_reg_ff[`RATE_MSB:`RATE_LSB]))
    else $error("sample rate does not follow sleep register");
  a_no_fault_clocked: assert property (@(posedge mclk) disable iff (!resetn)
    (unit_access && unit_on(act_gate, unit_sel))
    |=> !unit_fault)
    else $error("clocked unit access faulted");
  a_pready_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    pready
    |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (@(posedge mclk) disable iff (!resetn)
    pslverr
    |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!resetn)
    !pready
    |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!resetn)
    ##1
    irq == $past(|(status_ff & mask_ff)))
    else $error("interrupt does not follow masked status");
  a_mode_sets_status: assert property (@(posedge mclk) disable iff (!resetn)
    mode_wr
    |=> status_ff[`EVT_MODE_BIT])
    else $error("mode write did not set status");
  a_reserved_run: assert property (@(posedge mclk) disable iff (!resetn)
    (run_clock_gate_reg_ff & ~`GATE_WR_MASK)
    == 32'h0)
    else $error("reserved run bits not zero");
  a_reserved_deep: assert property (@(posedge mclk) disable iff (!resetn)
    (deep_sleep_clock_gate_reg_ff & ~`GATE_WR_MASK)
    == 32'h0)
    else $error("reserved deep bits not zero");
endmodule : sleep_clock_gating

// ---- rtl/sleep_gate_map.svh ----
`ifndef SLEEP_GATE_MAP_SVH
`define SLEEP_GATE_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RUN_GATE_OFS     12'h100
`define SLEEP_GATE_OFS   12'h110
`define DEEP_GATE_OFS    12'h120
`define RUN_CFG_OFS      12'h060
`define MODE_CTRL_OFS    12'h070
`define INT_STATUS_OFS   12'h074
`define INT_MASK_OFS     12'h078
// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define PWM_BIT          20
`define ADC_BIT          16
`define RATE_LSB         8
`define RATE_MSB         9
`define HIB_BIT          6
`define WDT_BIT          3
`define GATE_WR_MASK     32'h00110348
`define ACG_BIT          27
`define CFG_WR_MASK      32'h08000000
`define MODE_WR_MASK     32'h00000003
`define INT_WR_MASK      32'h00000003
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define GATE_RESET       32'h00000040
`define CFG_RESET        32'h00000000
`define RATE_500K        2'h2
`define RATE_250K        2'h1
`define RATE_125K        2'h0
`define UNIT_PWM         2'h0
`define UNIT_ADC         2'h1
`define UNIT_WDT         2'h2
`define UNIT_HIB         2'h3
`define EVT_FAULT_BIT    0
`define EVT_MODE_BIT     1
`endif

// ---- rtl/sleep_gate_pkg.sv ----
package sleep_gate_pkg;
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_t;
endpackage : sleep_gate_pkg

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`include "sleep_gate_map.svh"
module testbench;
  logic        mclk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        unit_access;
  logic [1:0]  unit_sel;
  logic        unit_fault;
  logic        pwm_clk_en;
  logic        adc_clk_en;
  logic        wdt_clk_en;
  logic        hib_clk_en;
  logic [1:0]  converter_sample_rate;
  logic        irq;
  int          mismatches;
  int          checks;
  int          i;
  int          s;
  logic [31:0] rd;
  logic        err;
  logic [31:0] one_bit [4];

  sleep_clock_gating dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unit_access(unit_access), .unit_sel(unit_sel),
    .unit_fault(unit_fault), .pwm_clk_en(pwm_clk_en), .adc_clk_en(adc_clk_en),
    .wdt_clk_en(wdt_clk_en), .hib_clk_en(hib_clk_en),
    .converter_sample_rate(converter_sample_rate), .irq(irq));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // enables packed pwm, converter, watchdog, hibernation
  task chk_en(input logic [3:0] exp);
    chk({28'h0, pwm_clk_en, adc_clk_en, wdt_clk_en, hib_clk_en}, {28'h0, exp});
  endtask : chk_en

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      mismatches++;
      $display("MISMATCH at %0t: no pready", $time);
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task unit(input logic [1:0] u, input logic exp);
    @(posedge mclk);
    unit_access <= 1'b1;
    unit_sel    <= u;
    @(posedge mclk);
    unit_access <= 1'b0;
    #1;
    chk({31'h0, unit_fault}, {31'h0, exp});
  endtask : unit

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    mismatches = 0;
    checks = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    unit_access = 1'b0;
    unit_sel = 2'h0;
    one_bit = '{32'h00100000, 32'h00010000, 32'h00000008, 32'h00000040};
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    cyc(1);
    chk_en(4'h1);
    chk({30'h0, converter_sample_rate}, 32'h0);
    apb(1'b0, `SLEEP_GATE_OFS, 32'h0);
    chk(rd, 32'h00000040);
    unit(2'h0, 1'b1);
    unit(2'h3, 1'b0);
    // sleep with auto gating selected
    apb(1'b1, `RUN_CFG_OFS, 32'h08000000);
    apb(1'b1, `MODE_CTRL_OFS, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, `SLEEP_GATE_OFS, one_bit[i]);
      cyc(2);
      chk_en(4'h8 >> i);
      for (s = 0; s < 4; s++)
        unit(2'(s), s != i);
    end
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, `SLEEP_GATE_OFS, 32'h40 | (i << 8));
      cyc(2);
      chk({30'h0, converter_sample_rate}, 32'(i));
    end
    // reserved bits stay zero, rate field set to 2
    apb(1'b1, `SLEEP_GATE_OFS, 32'hFFFFFEFF);
    apb(1'b0, `SLEEP_GATE_OFS, 32'h0);
    chk(rd, 32'h00110248);
    cyc(2);
    chk_en(4'hF);
    // mode selects which register applies
    apb(1'b1, `RUN_GATE_OFS, 32'h00010000);
    apb(1'b1, `MODE_CTRL_OFS, 32'h0);
    cyc(2);
    chk_en(4'h4);
    chk({30'h0, converter_sample_rate}, 32'h0);
    apb(1'b1, `MODE_CTRL_OFS, 32'h2);
    cyc(2);
    chk_en(4'h1);
    apb(1'b1, `RUN_CFG_OFS, 32'h0);
    cyc(2);
    chk_en(4'h4);
    apb(1'b1, `MODE_CTRL_OFS, 32'h1);
    cyc(2);
    chk_en(4'h4);
    // unmapped addresses
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h204, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    // fault interrupt, masked and unmasked
    apb(1'b1, `INT_MASK_OFS, 32'h1);
    apb(1'b0, `INT_STATUS_OFS, 32'h0);
    apb(1'b0, `INT_STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    unit(2'h0, 1'b1);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `INT_STATUS_OFS, 32'h0);
    chk(rd, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `INT_MASK_OFS, 32'h0);
    unit(2'h2, 1'b1);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `INT_STATUS_OFS, 32'h0);
    chk(rd, 32'h1);
    summarize();
  end
endmodule : testbench
